//--- core/cmpd_comparator_event.sv
// Purpose: Comparator output gating, event flag, debounce and APB registers
// Assumes: Comparator and Port 3 pins are asynchronous; timer overflow is a clk pulse
// Notes: APB answers with no wait states
`timescale 1ns/100ps
`default_nettype none
module cmpd_comparator_event (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cmpd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog core
    input wire logic comp_raw,
    output logic comp_power_on,
    // Port 3 and timer
    input wire logic [7:0] p3_pins,
    output logic [7:0] p3_latch,
    input wire logic t1_overflow,
    // CPU side
    output logic comp_out,
    output logic irq,
    output logic wake
);
    typedef cmpd_pkg::cmpd_db_t cmpd_db_t;
    typedef struct packed {
        logic idle_run;
        logic flag;
        logic on;
        logic [2:0] mode;
        logic [7:0] p3;
        logic [7:0] ie;
        logic idle;
        logic pdown;
        logic prev;
        cmpd_db_t db;
        logic want_level;
        logic [1:0] ovf_cnt;
        logic [9:0] settle;
        logic [31:0] rdata;
        logic err;
        logic wake;
    } cmpd_state_t;

    cmpd_state_t s, s_next;
    logic [8:0] sync_q;
    logic cmp_sync;
    logic [7:0] pins_sync;
    logic active;
    logic cmp_now;
    logic rise;
    logic fall;
    logic raw_set;
    logic trig;
    logic deb_mode;
    logic deb_set;
    logic set_evt;
    logic setup;
    logic wr_acc;
    logic hit;
    logic [31:0] rd_word;

    // Comparator and pins both come from outside the clock domain
    cmpd_sync #(
        .W(9)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d({comp_raw, p3_pins}),
        .q(sync_q)
    );
    assign cmp_sync = sync_q[8];
    assign pins_sync = sync_q[7:0];

    // Comparator alive only when on, not powered down, and idle permits it
    assign active = s.on & ~s.pdown & (~s.idle | s.idle_run); // RULE2 RULE12 RULE14
    // comp_raw is high exactly when positive input exceeds negative input while powered
    assign cmp_now = active & cmp_sync; // RULE1 RULE8
    assign rise = cmp_now & ~s.prev;
    assign fall = ~cmp_now & s.prev;

    // Raw per-clock conditions
    always_comb begin
        raw_set = 1'b0;
        trig = 1'b0;
        deb_mode = 1'b0;
        case (s.mode)
            cmpd_pkg::MODE_LOW: raw_set = ~cmp_now; // RULE15 RULE19
            cmpd_pkg::MODE_HIGH: raw_set = cmp_now; // RULE15 RULE19
            cmpd_pkg::MODE_RISE: raw_set = rise; // RULE15
            cmpd_pkg::MODE_FALL: raw_set = fall; // RULE15
            cmpd_pkg::MODE_TOG: raw_set = rise | fall; // RULE15
            cmpd_pkg::MODE_DB_TOG: begin
                trig = rise | fall; // RULE16
                deb_mode = 1'b1;
            end
            cmpd_pkg::MODE_DB_RISE: begin
                trig = rise; // RULE16
                deb_mode = 1'b1;
            end
            cmpd_pkg::MODE_DB_FALL: begin
                trig = fall; // RULE16
                deb_mode = 1'b1;
            end
            default: raw_set = 1'b0;
        endcase
    end

    // APB decode; unmapped addresses answer with an error
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & ~s.err;
    always_comb begin
        hit = 1'b1;
        rd_word = 32'h0;
        if (paddr == cmpd_pkg::ADDR_CTRL) begin
            rd_word = {26'h0, s.idle_run, s.flag, s.on, s.mode}; // RULE18
        end else if (paddr == cmpd_pkg::ADDR_P3_LATCH) begin
            rd_word = {24'h0, s.p3};
        end else if (paddr == cmpd_pkg::ADDR_P3_PINS) begin
            // Pin 6 reads the comparator, not the pad
            rd_word = {24'h0, pins_sync[7], s.prev, pins_sync[5:0]}; // RULE4
        end else if (paddr == cmpd_pkg::ADDR_INT_EN) begin
            rd_word = {24'h0, s.ie};
        end else if (paddr == cmpd_pkg::ADDR_POWER) begin
            rd_word = {24'h0, s.settle == cmpd_pkg::SETTLE_CYC, 5'h0, s.pdown, s.idle};
        end else begin
            hit = 1'b0;
        end
    end

    // Next state
    always_comb begin
        s_next = s;
        deb_set = 1'b0;
        s_next.wake = 1'b0;
        s_next.prev = cmp_now; // RULE8
        // Debounce sequencer: further edges are ignored while waiting
        case (s.db)
            cmpd_pkg::CMPD_DB_IDLE: begin
                if (active && trig) begin
                    s_next.db = cmpd_pkg::CMPD_DB_WAIT; // RULE9
                    s_next.want_level = cmp_now;
                    s_next.ovf_cnt = 2'h0;
                end
            end
            cmpd_pkg::CMPD_DB_WAIT: begin
                if (!active || !deb_mode) begin
                    s_next.db = cmpd_pkg::CMPD_DB_IDLE;
                end else if (t1_overflow) begin
                    // Free-running timer: two overflows guarantee a full period
                    if (s.ovf_cnt == cmpd_pkg::DEB_OVERFLOWS - 2'h1) begin
                        s_next.db = cmpd_pkg::CMPD_DB_IDLE; // RULE11
                        deb_set = (cmp_now == s.want_level); // RULE10
                    end else begin
                        s_next.ovf_cnt = s.ovf_cnt + 2'h1; // RULE9
                    end
                end
            end
            default: s_next.db = cmpd_pkg::CMPD_DB_IDLE;
        endcase
        set_evt = active & (raw_set | deb_set); // RULE6 RULE2
        // Settle timer for the 10 us start-up, visible in the power register
        if (!active) begin
            s_next.settle = 10'h0;
        end else if (s.settle != cmpd_pkg::SETTLE_CYC) begin
            s_next.settle = s.settle + 10'h1;
        end
        // Read data and error captured in setup so they come from flops
        if (setup) begin
            s_next.rdata = pwrite ? 32'h0 : rd_word;
            s_next.err = ~hit;
        end
        // Register writes at the access edge
        if (wr_acc) begin
            if (paddr == cmpd_pkg::ADDR_CTRL) begin
                s_next.idle_run = pwdata[cmpd_pkg::BIT_IDLE_RUN];
                s_next.flag = pwdata[cmpd_pkg::BIT_FLAG]; // RULE6
                s_next.on = pwdata[cmpd_pkg::BIT_ON];
                s_next.mode = pwdata[2:0];
            end else if (paddr == cmpd_pkg::ADDR_P3_LATCH) begin
                s_next.p3 = pwdata[7:0]; // RULE5
            end else if (paddr == cmpd_pkg::ADDR_INT_EN) begin
                s_next.ie = pwdata[7:0];
            end else if (paddr == cmpd_pkg::ADDR_POWER) begin
                s_next.idle = pwdata[cmpd_pkg::PWR_IDLE_BIT];
                s_next.pdown = pwdata[cmpd_pkg::PWR_PDOWN_BIT];
            end
        end
        // Hardware set wins over a software clear in the same cycle
        if (set_evt) begin
            s_next.flag = 1'b1; // RULE6 RULE19
        end
        // Event during Idle with interrupt enabled wakes the CPU
        if (set_evt && s.idle && s.ie[cmpd_pkg::IE_CMP_BIT]) begin
            s_next.idle = 1'b0; // RULE13
            s_next.wake = 1'b1;
        end
    end

    // State flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '{idle_run: 1'b0, flag: 1'b0, on: 1'b0, mode: 3'h0,
                   p3: cmpd_pkg::P3_RESET, ie: cmpd_pkg::IE_RESET,
                   idle: 1'b0, pdown: 1'b0, prev: 1'b0,
                   db: cmpd_pkg::CMPD_DB_IDLE, want_level: 1'b0,
                   ovf_cnt: 2'h0, settle: 10'h0, rdata: 32'h0,
                   err: 1'b0, wake: 1'b0}; // RULE18
        end else begin
            s <= s_next;
        end
    end

    // Outputs
    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & s.err;
    assign comp_power_on = active; // RULE14
    assign comp_out = s.prev;
    assign p3_latch = s.p3;
    assign irq = s.flag & s.ie[cmpd_pkg::IE_CMP_BIT]; // RULE7
    assign wake = s.wake;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic ctrl_wr;
    assign ctrl_wr = wr_acc && paddr == cmpd_pkg::ADDR_CTRL;

    sequence deb_start_s;
        s.db == cmpd_pkg::CMPD_DB_IDLE && active && trig;
    endsequence
    sequence deb_last_s;
        s.db == cmpd_pkg::CMPD_DB_WAIT && active && deb_mode && t1_overflow && s.ovf_cnt == 2'h1;
    endsequence

    off_output_low_a: assert property (!s.on |=> !comp_out) // RULE2
        else $error("comparator output not low while off");
    off_no_flag_a: assert property (!active && !s.flag && !ctrl_wr |=> !s.flag) // RULE2
        else $error("flag set while comparator inactive");
    flag_sticky_a: assert property (s.flag && !ctrl_wr |=> s.flag) // RULE6
        else $error("flag cleared without a software write");
    irq_follow_a: assert property ($rose(s.flag) && s.ie[cmpd_pkg::IE_CMP_BIT] |-> irq) // RULE7
        else $error("interrupt missing for enabled flag");
    pin6_read_a: assert property (setup && !pwrite && paddr == cmpd_pkg::ADDR_P3_PINS // RULE4
        |=> prdata[cmpd_pkg::P3_CMP_BIT] == $past(comp_out))
        else $error("pin read bit 6 is not the comparator");
    latch_iso_a: assert property (wr_acc && paddr == cmpd_pkg::ADDR_P3_LATCH // RULE5
        |=> $stable({s.on, s.mode, s.idle_run}))
        else $error("port latch write disturbed the comparator");
    low_level_a: assert property (active && s.mode == cmpd_pkg::MODE_LOW && !cmp_now |=> s.flag) // RULE15
        else $error("low level did not set flag");
    rise_edge_a: assert property (active && s.mode == cmpd_pkg::MODE_RISE && rise |=> s.flag) // RULE15
        else $error("rising edge did not set flag");
    deb_arm_a: assert property (deb_start_s |=> s.db == cmpd_pkg::CMPD_DB_WAIT && s.ovf_cnt == 2'h0) // RULE9
        else $error("debounce did not arm on transition");
    deb_reject_a: assert property (deb_last_s ##0 (cmp_now != s.want_level && !s.flag && !ctrl_wr) // RULE10
        |=> !s.flag)
        else $error("mismatched resample set the flag");
    deb_accept_a: assert property (deb_last_s ##0 (cmp_now == s.want_level) |=> s.flag) // RULE11
        else $error("matching resample did not set flag");
    pdown_off_a: assert property (s.pdown |-> !comp_power_on ##1 !comp_out) // RULE14
        else $error("comparator alive in power-down");
    idle_wake_a: assert property (set_evt && s.idle && s.ie[cmpd_pkg::IE_CMP_BIT] |=> wake && !s.idle) // RULE13
        else $error("idle event did not wake the CPU");

    // Remaining raw conditions; rise and toggle modes never set without a transition
    fall_edge_a: assert property (active && s.mode == cmpd_pkg::MODE_FALL && fall // RULE15
        |=> s.flag)
        else $error("falling edge did not set flag");
    toggle_edge_a: assert property (active && s.mode == cmpd_pkg::MODE_TOG && (rise || fall) // RULE15
        |=> s.flag)
        else $error("toggle did not set flag");
    high_level_a: assert property (active && s.mode == cmpd_pkg::MODE_HIGH && cmp_now // RULE15
        |=> s.flag)
        else $error("high level did not set flag");
    rise_once_a: assert property (s.mode == cmpd_pkg::MODE_RISE && !rise && !s.flag && !ctrl_wr // RULE19
        |=> !s.flag)
        else $error("rising mode set flag without an edge");
    tog_once_a: assert property (s.mode == cmpd_pkg::MODE_TOG && !rise && !fall && !s.flag && !ctrl_wr // RULE19
        |=> !s.flag)
        else $error("toggle mode set flag without a transition");

    // Software clear and register side effects
    flag_clear_a: assert property (ctrl_wr && !pwdata[cmpd_pkg::BIT_FLAG] && !set_evt // RULE6
        |=> !s.flag)
        else $error("software clear of flag lost");
    latch_write_a: assert property (wr_acc && paddr == cmpd_pkg::ADDR_P3_LATCH // RULE5
        |=> p3_latch == $past(pwdata[7:0]))
        else $error("port latch write not stored");
    ctrl_upper_a: assert property (setup && !pwrite && paddr == cmpd_pkg::ADDR_CTRL // RULE18
        |=> prdata[31:6] == 26'h0)
        else $error("unused control bits not zero");

    // Debounce counting between the two overflows
    sequence deb_wait_s;
        s.db == cmpd_pkg::CMPD_DB_WAIT && active && deb_mode;
    endsequence
    deb_hold_a: assert property (deb_wait_s ##0 !t1_overflow // RULE9
        |=> s.db == cmpd_pkg::CMPD_DB_WAIT && $stable(s.ovf_cnt))
        else $error("debounce moved without an overflow");
    deb_count_a: assert property (deb_wait_s ##0 (t1_overflow && s.ovf_cnt == 2'h0) // RULE9
        |=> s.db == cmpd_pkg::CMPD_DB_WAIT && s.ovf_cnt == 2'h1)
        else $error("first overflow not counted");
    deb_done_a: assert property (deb_last_s // RULE9
        |=> s.db == cmpd_pkg::CMPD_DB_IDLE)
        else $error("debounce did not finish on second overflow");
    deb_want_a: assert property (deb_start_s // RULE10
        |=> s.want_level == $past(cmp_now))
        else $error("debounce stored wrong expected level");
    deb_no_raw_a: assert property (deb_mode && s.db == cmpd_pkg::CMPD_DB_IDLE && !s.flag && !ctrl_wr // RULE16
        |=> !s.flag)
        else $error("debounce mode set flag without resample");

    // Idle, power-down and wake
    idle_off_a: assert property (s.idle && !s.idle_run // RULE12
        |=> !comp_out)
        else $error("comparator output alive in idle");
    idle_run_a: assert property (s.on && s.idle && s.idle_run && !s.pdown // RULE12
        |-> comp_power_on)
        else $error("comparator stopped in idle with idle running");
    pdown_flag_a: assert property (s.pdown && !s.flag && !ctrl_wr // RULE14
        |=> !s.flag)
        else $error("flag set in power-down");
    wake_pulse_a: assert property (wake // RULE13
        |=> !wake)
        else $error("wake longer than one cycle");
    no_wake_a: assert property (!s.idle // RULE13
        |=> !wake)
        else $error("wake outside idle");
    wake_flag_a: assert property (wake // RULE13
        |-> s.flag)
        else $error("wake without the event flag");
endmodule : cmpd_comparator_event
`default_nettype wire

//--- core/cmpd_pkg.sv
// Purpose: Constants for the comparator event and debounce block
// Assumes: 100 MHz clk, APB with 32-bit data, one word per register
// Notes: Printed offsets are register indices; byte address is four times
// What this block does
// RULE1: Comparator result is one only when positive input exceeds negative input.
// RULE2: With comparator_on clear, output is held low and no event sets the flag.
// RULE3: Software waits 10 us after enabling, clears flag before enabling interrupt.
// RULE4: Reading Port 3 pins returns live comparator output in bit 6.
// RULE5: Writes to Port 3 bit 6 touch only the latch, never the comparator.
// RULE6: Flag sets on the selected condition while enabled; only software clears it.
// RULE7: Flag raises the interrupt only while interrupt enable bit 6 is set.
// RULE8: Comparator output is sampled every clock for non-debounced conditions.
// RULE9: Debounce modes wait two Timer 1 overflows after a transition, then resample.
// RULE10: Debounced flag sets only if resample matches expected value, else discarded.
// RULE11: Debounced flag comes between one and two Timer 1 periods after the edge.
// RULE12: In Idle the comparator runs only when idle_keep_running is one.
// RULE13: With idle running and interrupt enabled, an event during Idle wakes the CPU.
// RULE14: The comparator is always disabled in Power-down.
// RULE15: Modes 000 low, 001 rise, 100 fall, 101 toggle, 111 high, raw samples.
// RULE16: Modes 010 debounced toggle, 011 debounced rise, 110 debounced fall.
// RULE17: Software puts both analog input pins in input-only mode before enabling.
// RULE18: Control/status resets low six bits zero; bits 5 idle, 4 flag, 3 on, 2:0 mode.
// RULE19: Level modes set the flag every clock; edge modes once per transition.
package cmpd_pkg;
    localparam int ADDR_W = 12;
    // Register indices and byte addresses
    localparam logic [7:0] IDX_CTRL = 8'h97;
    localparam logic [7:0] IDX_P3_LATCH = 8'h40;
    localparam logic [7:0] IDX_P3_PINS = 8'h41;
    localparam logic [7:0] IDX_INT_EN = 8'h42;
    localparam logic [7:0] IDX_POWER = 8'h43;
    localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] ADDR_P3_LATCH = {2'h0, IDX_P3_LATCH, 2'h0};
    localparam logic [11:0] ADDR_P3_PINS = {2'h0, IDX_P3_PINS, 2'h0};
    localparam logic [11:0] ADDR_INT_EN = {2'h0, IDX_INT_EN, 2'h0};
    localparam logic [11:0] ADDR_POWER = {2'h0, IDX_POWER, 2'h0};
    // Control/status fields
    localparam int BIT_IDLE_RUN = 5;
    localparam int BIT_FLAG = 4;
    localparam int BIT_ON = 3;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam int P3_CMP_BIT = 6;
    localparam int IE_CMP_BIT = 6;
    localparam logic [7:0] P3_RESET = 8'hFF;
    localparam logic [7:0] IE_RESET = 8'h00;
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_PDOWN_BIT = 1;
    localparam int PWR_SETTLED_BIT = 7;
    // Event condition encodings
    localparam logic [2:0] MODE_LOW = 3'h0;
    localparam logic [2:0] MODE_RISE = 3'h1;
    localparam logic [2:0] MODE_DB_TOG = 3'h2;
    localparam logic [2:0] MODE_DB_RISE = 3'h3;
    localparam logic [2:0] MODE_FALL = 3'h4;
    localparam logic [2:0] MODE_TOG = 3'h5;
    localparam logic [2:0] MODE_DB_FALL = 3'h6;
    localparam logic [2:0] MODE_HIGH = 3'h7;
    // Timing
    localparam logic [1:0] DEB_OVERFLOWS = 2'h2;
    localparam int SETTLE_US = 10;
    localparam int CLK_MHZ = 100;
    localparam logic [9:0] SETTLE_CYC = 10'(SETTLE_US * CLK_MHZ);
    typedef enum logic {CMPD_DB_IDLE, CMPD_DB_WAIT} cmpd_db_t;
endpackage : cmpd_pkg

//--- core/cmpd_sync.sv
// Purpose: Two-flop synchroniser for asynchronous inputs
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module cmpd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cmpd_sync_t;
    cmpd_sync_t s, s_next;

    // Shift chain
    always_comb begin
        s_next.s1 = d;
        s_next.s2 = s.s1;
    end

    // State flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= s_next;
        end
    end

    assign q = s.s2;
endmodule : cmpd_sync
`default_nettype wire

//--- testbench/cmpd_analog_model.sv
// Purpose: Analog comparator core and free running Timer 1 stand-in
// Assumes: Bench gives both input levels in millivolts
// Notes: An unpowered core gives noise, so a stale level never passes
`timescale 1ns/100ps
`default_nettype none
module cmpd_analog_model #(
    parameter int T1P = 40
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Analog levels and power; pins are sensed only, never driven
    input wire logic [11:0] pos_mv,
    input wire logic [11:0] neg_mv,
    input wire logic power_on,
    // Outputs
    output logic comp_raw,
    output logic t1_overflow
);
    logic junk;
    int t1_cnt;
    // One only when positive strictly exceeds negative
    assign comp_raw = power_on ? (pos_mv > neg_mv) : junk;
    // Noise source and overflow pulse every T1P clocks
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            junk <= 1'b0;
            t1_cnt <= 0;
            t1_overflow <= 1'b0;
        end else begin
            junk <= ~junk;
            t1_cnt <= (t1_cnt == T1P - 1) ? 0 : t1_cnt + 1;
            t1_overflow <= (t1_cnt == T1P - 1);
        end
    end
endmodule : cmpd_analog_model
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the comparator event block
// Assumes: APB answers with no wait states; bench still waits for pready
// Notes: Debounce timing uses a short Timer 1 period to keep runs brief
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int T1P = 40;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic comp_raw;
    logic comp_power_on;
    logic [7:0] p3_pins = 8'hA5;
    logic [7:0] p3_latch;
    logic t1_overflow;
    logic comp_out;
    logic irq;
    logic wake;
    logic [11:0] pos_mv = 12'h200;
    logic [11:0] neg_mv = 12'h400;
    int err_total = 0;
    int total_checks = 0;

    // Half period of 5 ns gives 100 MHz
    always #5 clk = ~clk;

    cmpd_comparator_event DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comp_raw(comp_raw), .comp_power_on(comp_power_on),
        .p3_pins(p3_pins), .p3_latch(p3_latch), .t1_overflow(t1_overflow),
        .comp_out(comp_out), .irq(irq), .wake(wake));

    cmpd_analog_model #(.T1P(T1P)) partner (.clk(clk), .rst(rst), .pos_mv(pos_mv),
        .neg_mv(neg_mv), .power_on(comp_power_on), .comp_raw(comp_raw),
        .t1_overflow(t1_overflow));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n

    // Analog input above or below the fixed negative level
    task automatic lvl(input logic hi);
        @(posedge clk);
        pos_mv <= hi ? 12'h600 : 12'h200;
    endtask : lvl

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(cmpd_pkg::ADDR_CTRL, r);
        chk("ctrl_reset", r, 32'h0);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        wr(cmpd_pkg::ADDR_CTRL, 8'hFF);
        rd(cmpd_pkg::ADDR_CTRL, r);
        chk("ctrl_fields", r, 32'h3F);
        wr(cmpd_pkg::ADDR_CTRL, 8'h07);
        lvl(1'b1);
        wait_n(10);
        chk("off_out", {31'h0, comp_out}, 32'h0);
        rd(cmpd_pkg::ADDR_CTRL, r);
        chk("off_flag", {31'h0, r[4]}, 32'h0);
        $display("test regs done");
    endtask : t_regs

    // Each raw mode: no flag at start level, flag after change, level modes re-set
    task automatic t_modes();
        logic [2:0] md[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h7};
        logic st[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        logic lv[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        logic [31:0] r;
        for (int i = 0; i < 5; i++) begin
            lvl(st[i]);
            wr(cmpd_pkg::ADDR_CTRL, {5'h01, md[i]});
            wait_n(10);
            wr(cmpd_pkg::ADDR_CTRL, {5'h01, md[i]});
            wait_n(5);
            rd(cmpd_pkg::ADDR_CTRL, r);
            chk("mode_quiet", {31'h0, r[4]}, 32'h0);
            lvl(!st[i]);
            wait_n(8);
            rd(cmpd_pkg::ADDR_CTRL, r);
            chk("mode_set", {31'h0, r[4]}, 32'h1);
            wr(cmpd_pkg::ADDR_CTRL, {5'h01, md[i]});
            wait_n(5);
            rd(cmpd_pkg::ADDR_CTRL, r);
            chk("mode_reset", {31'h0, r[4]}, {31'h0, lv[i]});
        end
        rd(cmpd_pkg::ADDR_P3_PINS, r);
        chk("pin_read", r, {24'h0, p3_pins[7], 1'b1, p3_pins[5:0]});
        wr(cmpd_pkg::ADDR_P3_LATCH, 8'h00);
        wait_n(1);
        chk("latch", {24'h0, p3_latch}, 32'h0);
        chk("out_kept", {31'h0, comp_out}, 32'h1);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wr(cmpd_pkg::ADDR_INT_EN, 8'h40);
        wait_n(2);
        chk("irq_on", {31'h0, irq}, 32'h1);
        $display("test modes done");
    endtask : t_modes

    task automatic t_debounce();
        logic [2:0] dm[3] = '{3'h6, 3'h3, 3'h2};
        logic st[3] = '{1'b1, 1'b0, 1'b1};
        int n;
        for (int i = 0; i < 3; i++) begin
            lvl(st[i]);
            wr(cmpd_pkg::ADDR_CTRL, {5'h01, dm[i]});
            wait_n(3 * T1P);
            wr(cmpd_pkg::ADDR_CTRL, {5'h01, dm[i]});
            if (i < 2) begin
                lvl(!st[i]);
                wait_n(5);
                lvl(st[i]);
                wait_n(3 * T1P);
                chk("db_glitch", {31'h0, irq}, 32'h0);
            end
            lvl(!st[i]);
            n = 0;
            while (irq !== 1'b1 && n < 4 * T1P) begin
                @(negedge clk);
                n++;
            end
            chk("db_early", 32'(n >= T1P), 32'h1);
            chk("db_late", 32'(n <= 2 * T1P + 8), 32'h1);
        end
        $display("test debounce done");
    endtask : t_debounce

    task automatic t_power();
        int n;
        logic [31:0] r;
        lvl(1'b1);
        wr(cmpd_pkg::ADDR_CTRL, 8'h08);
        wr(cmpd_pkg::ADDR_POWER, 8'h01);
        wait_n(5);
        chk("idle_off", {30'h0, comp_power_on, comp_out}, 32'h0);
        wr(cmpd_pkg::ADDR_POWER, 8'h00);
        // Output is trusted only after the start-up time has run
        rd(cmpd_pkg::ADDR_POWER, r);
        chk("not_settled", {31'h0, r[7]}, 32'h0);
        wait_n(int'(cmpd_pkg::SETTLE_CYC));
        rd(cmpd_pkg::ADDR_POWER, r);
        chk("settled", {31'h0, r[7]}, 32'h1);
        wr(cmpd_pkg::ADDR_CTRL, 8'h28);
        wr(cmpd_pkg::ADDR_POWER, 8'h01);
        chk("idle_on", {31'h0, comp_power_on}, 32'h1);
        lvl(1'b0);
        n = 0;
        while (wake !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("wake", {31'h0, wake}, 32'h1);
        wr(cmpd_pkg::ADDR_POWER, 8'h02);
        wait_n(2);
        chk("pdown_off", {31'h0, comp_power_on}, 32'h0);
        wr(cmpd_pkg::ADDR_CTRL, 8'h28);
        wait_n(5);
        rd(cmpd_pkg::ADDR_CTRL, r);
        chk("pdown_flag", {31'h0, r[4]}, 32'h0);
        wr(cmpd_pkg::ADDR_POWER, 8'h00);
        $display("test power done");
    endtask : t_power

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_modes();
        t_debounce();
        t_power();
        print_verdict();
    end

    // Whole run needs under 5000 clocks; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
